// ### hdl/bfcc_pkg.sv
// Constants shared by the boot-flag configuration block.
// Assumes a single 125 MHz clock and a synchronous active-high reset.
package bfcc_pkg;
   // ==========================================================
   // Timing
   // ==========================================================
   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned SUPPLY_DELAY_MS = 2000;
   localparam longint unsigned SUPPLY_DELAY_CYC =
      longint'(SUPPLY_DELAY_MS) * longint'(CLK_HZ) / 64'd1000;
   localparam int unsigned BAUD_SLOW = 57600;
   localparam int unsigned BAUD_FAST = 115200;
   localparam logic [15:0] BAUD_DIV_SLOW = 16'(CLK_HZ / BAUD_SLOW);
   localparam logic [15:0] BAUD_DIV_FAST = 16'(CLK_HZ / BAUD_FAST);
   // Peaking-time limits in units of 0.1 us.
   localparam logic [10:0] PEAK_MIN_20 = 11'd8;
   localparam logic [10:0] PEAK_MAX_20 = 11'd1020;
   localparam logic [10:0] PEAK_MIN_80 = 11'd2;
   // Fast-channel peaking time in ns.
   localparam logic [10:0] FAST_NS_20 = 11'd400;
   localparam logic [10:0] FAST_NS_80 = 11'd100;
   localparam logic [10:0] FAST_NS_20_SLOW = 11'd1600;
   localparam logic [10:0] FAST_NS_80_SLOW = 11'd400;
   // Status byte bit that shows configured state.
   localparam int unsigned STATUS_CFG_BIT = 1;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // ==========================================================
   // Power sequencer states
   // ==========================================================
   typedef enum logic [1:0] {
      BFCC_WAIT = 2'b00,
      BFCC_DELAY = 2'b01,
      BFCC_ON = 2'b11
   } bfcc_pwr_t;
endpackage : bfcc_pkg

// ### hdl/bfcc_sample_sel.sv
// Per-sample data path: ADC inversion and histogram source selection.
// Assumes samples are synchronous to clk.
`timescale 1ns/1ps
module bfcc_sample_sel #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic invert,
   input wire logic use_fast,
   input wire logic [W-1:0] adc_in,
   input wire logic [W-1:0] slow_in,
   input wire logic [W-1:0] fast_in,
   output logic [W-1:0] adc_out,
   output logic [W-1:0] hist_out
);
   // ==========================================================
   // Registered selection
   // ==========================================================
   // Inversion is a bitwise complement so it costs no carry chain.
   always_ff @(posedge clk) begin
      adc_out <= invert ? ~adc_in : adc_in;
      hist_out <= use_fast ? fast_in : slow_in;
   end
endmodule : bfcc_sample_sel

// ### hdl/bfcc_offset_add.sv
// Adds the spectrum offset to the baseline-restored value when enabled.
// Assumes both inputs are synchronous to clk.
`timescale 1ns/1ps
module bfcc_offset_add #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic enable,
   input wire logic [W-1:0] restored,
   input wire logic [W-1:0] offset,
   output logic [W-1:0] result
);
   // ==========================================================
   // Offset adder
   // ==========================================================
   // Wraps on overflow; the host keeps offsets small.
   always_ff @(posedge clk) begin
      result <= enable ? W'(restored + offset) : restored;
   end
endmodule : bfcc_offset_add

// ### hdl/bfcc_top.sv
// Boot-flag configuration control: latches power-cycle flags after reset,
// sequences detector supplies and applies live processing settings.
// Assumes rst is asserted once at power-up and inputs are synchronous.
`timescale 1ns/1ps
module bfcc_top #(
   parameter int W = 16,
   parameter longint unsigned SUPPLY_DELAY = bfcc_pkg::SUPPLY_DELAY_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic flag_nv_boot,
   input wire logic flag_baud_fast,
   input wire logic flag_pol_pos,
   input wire logic flag_adc_invert,
   input wire logic flag_fast_slow4,
   input wire logic flag_use_offset,
   input wire logic [W-1:0] flag_offset,
   input wire logic flag_write,
   input wire logic strap_pol_pos,
   input wire logic clk80_sel,
   input wire logic legacy_emul,
   input wire logic pkt_invert,
   input wire logic cfg_packet,
   input wire logic supply_on_cmd,
   input wire logic nv_bias_on,
   input wire logic nv_cooler_on,
   input wire logic pkt_bias_on,
   input wire logic pkt_cooler_on,
   input wire logic peak_minmax_cmd,
   input wire logic peak_minmax_we,
   input wire logic hist_fast_cmd,
   input wire logic hist_fast_we,
   input wire logic upload_start,
   input wire logic upload_done,
   input wire logic [10:0] peak_req,
   input wire logic [W-1:0] adc_in,
   input wire logic [W-1:0] restored,
   input wire logic [W-1:0] shaped,
   input wire logic [W-1:0] fast_in,
   output logic configured,
   output logic [7:0] status_byte23,
   output logic supply_board_en,
   output logic detector_bias_supply_en,
   output logic thermoelectric_cooler_supply_en,
   output logic pol_mismatch,
   output logic [15:0] baud_div,
   output logic [10:0] fast_peak_ns,
   output logic [10:0] peak_eff,
   output logic [W-1:0] adc_out,
   output logic [W-1:0] hist_data,
   output logic hist_valid,
   output logic upload_busy
);
   import bfcc_pkg::*;

   // ==========================================================
   // Boot-flag store
   // ==========================================================
   // Flags live here, apart from the configuration packet state.
   logic st_nv;
   logic st_baud;
   logic st_pol;
   logic st_inv;
   logic st_slow4;
   logic st_use_off;
   logic [W-1:0] st_offset;
   logic first;

   // Writes only update the store; the store has no reset because it is
   // the nonvolatile copy that outlives the power cycle.
   always_ff @(posedge clk) begin
      if (flag_write) begin
         st_nv <= flag_nv_boot;
         st_baud <= flag_baud_fast;
         st_pol <= flag_pol_pos;
         st_inv <= flag_adc_invert;
         st_slow4 <= flag_fast_slow4;
         st_use_off <= flag_use_offset;
         st_offset <= flag_offset;
      end
   end

   // ==========================================================
   // Power-up latches
   // ==========================================================
   // Caught on the first edge after reset release, not under reset,
   // so the reset itself only loads constants.
   logic lt_nv;
   logic lt_baud;
   logic lt_pol;
   logic lt_inv;
   logic lt_slow4;

   always_ff @(posedge clk) begin
      if (rst) begin
         first <= 1'b1;
      end else begin
         first <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lt_nv <= 1'b0;
         lt_baud <= 1'b1;
         lt_pol <= 1'b0;
         lt_inv <= 1'b0;
         lt_slow4 <= 1'b0;
      end else if (first) begin
         lt_nv <= st_nv;
         lt_baud <= st_baud;
         lt_pol <= st_pol;
         lt_inv <= st_inv;
         lt_slow4 <= st_slow4;
      end
   end

   // ==========================================================
   // Live settings, volatile
   // ==========================================================
   logic minmax;
   logic hist_fast;

   always_ff @(posedge clk) begin
      if (rst) begin
         minmax <= 1'b0;
      end else if (peak_minmax_we) begin
         minmax <= peak_minmax_cmd;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         hist_fast <= 1'b0;
      end else if (hist_fast_we) begin
         hist_fast <= hist_fast_cmd;
      end
   end

   // ==========================================================
   // Configured state
   // ==========================================================
   // Valid from the cycle after the latch edge.
   logic armed;

   always_ff @(posedge clk) begin
      if (rst) begin
         armed <= 1'b0;
      end else begin
         armed <= armed | first;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         configured <= 1'b0;
      end else if (armed && (lt_nv || cfg_packet)) begin
         configured <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         status_byte23 <= STATUS_RESET;
      end else begin
         status_byte23 <= STATUS_RESET;
         status_byte23[STATUS_CFG_BIT] <= configured;
      end
   end

   // ==========================================================
   // Supply sequencer
   // ==========================================================
   bfcc_pwr_t pstate;
   bfcc_pwr_t next_pstate;
   logic [31:0] dcnt;
   logic want_bias;
   logic want_cool;
   logic pol_bad;

   assign pol_bad = (strap_pol_pos != lt_pol);

   // Nonvolatile boot waits the power-up delay; otherwise the host
   // must command the supply board after it has configured the unit.
   always_comb begin
      next_pstate = pstate;
      case (pstate)
         BFCC_WAIT: begin
            if (armed && lt_nv) begin
               next_pstate = BFCC_DELAY;
            end else if (armed && configured && supply_on_cmd) begin
               next_pstate = BFCC_ON;
            end
         end
         BFCC_DELAY: begin
            if (64'(dcnt) + 64'd1 >= SUPPLY_DELAY) begin
               next_pstate = BFCC_ON;
            end
         end
         BFCC_ON: next_pstate = BFCC_ON;
         default: next_pstate = BFCC_WAIT;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pstate <= BFCC_WAIT;
      end else begin
         pstate <= next_pstate;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || pstate != BFCC_DELAY) begin
         dcnt <= 32'h0000_0000;
      end else begin
         dcnt <= dcnt + 32'h0000_0001;
      end
   end

   // In nonvolatile boot, supplies that were stored on come back on, bias only without a polarity mismatch; packets may change them.
   always_ff @(posedge clk) begin
      if (rst) begin
         want_bias <= 1'b0;
         want_cool <= 1'b0;
      end else if (first) begin
         want_bias <= 1'b0;
         want_cool <= 1'b0;
      end else if (cfg_packet) begin
         want_bias <= pkt_bias_on;
         want_cool <= pkt_cooler_on;
      end else if (armed && lt_nv && pstate == BFCC_WAIT) begin
         want_bias <= nv_bias_on;
         want_cool <= nv_cooler_on;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         supply_board_en <= 1'b0;
         detector_bias_supply_en <= 1'b0;
         thermoelectric_cooler_supply_en <= 1'b0;
         pol_mismatch <= 1'b0;
      end else begin
         supply_board_en <= (pstate == BFCC_ON);
         detector_bias_supply_en <= (pstate == BFCC_ON) && want_bias
            && !pol_bad;
         thermoelectric_cooler_supply_en <= (pstate == BFCC_ON)
            && want_cool;
         pol_mismatch <= armed && pol_bad;
      end
   end

   // ==========================================================
   // Link rate and shaping figures
   // ==========================================================
   always_ff @(posedge clk) begin
      if (rst) begin
         baud_div <= BAUD_DIV_FAST;
         fast_peak_ns <= FAST_NS_20;
         peak_eff <= PEAK_MIN_20;
      end else begin
         baud_div <= lt_baud ? BAUD_DIV_FAST : BAUD_DIV_SLOW;
         if (clk80_sel) begin
            fast_peak_ns <= lt_slow4 ? FAST_NS_80_SLOW : FAST_NS_80;
            peak_eff <= (peak_req < PEAK_MIN_80) ? PEAK_MIN_80
               : peak_req;
         end else begin
            fast_peak_ns <= lt_slow4 ? FAST_NS_20_SLOW : FAST_NS_20;
            peak_eff <= (peak_req < PEAK_MIN_20) ? PEAK_MIN_20
               : (peak_req > PEAK_MAX_20) ? PEAK_MAX_20 : peak_req;
         end
      end
   end

   // ==========================================================
   // Sample path
   // ==========================================================
   logic inv_sel;
   logic [W-1:0] slow_val;
   logic [W-1:0] sh_d1;
   logic [W-1:0] sh_d2;
   logic is_max;
   logic is_min;

   assign inv_sel = legacy_emul ? lt_inv : pkt_invert;

   bfcc_offset_add #(.W(W)) u_off (
      .clk(clk),
      .enable(st_use_off),
      .restored(restored),
      .offset(st_offset),
      .result(slow_val)
   );

   bfcc_sample_sel #(.W(W)) u_sel (
      .clk(clk),
      .invert(inv_sel),
      .use_fast(hist_fast),
      .adc_in(adc_in),
      .slow_in(slow_val),
      .fast_in(fast_in),
      .adc_out(adc_out),
      .hist_out(hist_data)
   );

   // Local extremum of the shaped stream, one sample behind.
   always_ff @(posedge clk) begin
      sh_d1 <= shaped;
      sh_d2 <= sh_d1;
   end

   assign is_max = (sh_d1 > sh_d2) && (sh_d1 > shaped);
   assign is_min = (sh_d1 < sh_d2) && (sh_d1 < shaped);

   always_ff @(posedge clk) begin
      if (rst) begin
         hist_valid <= 1'b0;
      end else begin
         hist_valid <= configured && (is_max || (minmax && is_min));
      end
   end

   // ==========================================================
   // Firmware upload
   // ==========================================================
   // Busy until the loader reports completion; a power cycle follows.
   always_ff @(posedge clk) begin
      if (rst) begin
         upload_busy <= 1'b0;
      end else if (upload_start) begin
         upload_busy <= 1'b1;
      end else if (upload_done) begin
         upload_busy <= 1'b0;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   a_bias_interlock: assert property (@(posedge clk) disable iff (rst)
      pol_bad |=> !detector_bias_supply_en)
      else $error("bias supply on with polarity mismatch");
   a_unconf_off: assert property (@(posedge clk) disable iff (rst)
      !configured |-> !supply_board_en)
      else $error("supply on while unconfigured");
   a_status_bit: assert property (@(posedge clk) disable iff (rst)
      status_byte23[1] == $past(configured))
      else $error("status bit does not follow configured");
   a_latch_hold: assert property (@(posedge clk) disable iff (rst)
      !first |=> $stable(lt_baud))
      else $error("latched flag changed without power cycle");
   a_peak_floor: assert property (@(posedge clk) disable iff (rst)
      $past(clk80_sel) && !$past(rst) |-> peak_eff >= 11'd2)
      else $error("peaking time below floor");
   a_fast_ns: assert property (@(posedge clk) disable iff (rst)
      !clk80_sel && !lt_slow4 |=> fast_peak_ns == 11'd400)
      else $error("fast peaking time wrong");
   a_hist_src: assert property (@(posedge clk) disable iff (rst)
      hist_fast |=> hist_data == $past(fast_in))
      else $error("histogram source wrong");
   a_minmax_off: assert property (@(posedge clk) disable iff (rst)
      !minmax && !is_max |=> !hist_valid)
      else $error("minimum passed in max-only mode");
endmodule : bfcc_top

// ### sim/bfcc_host.sv
// Host computer model: sends configuration packets, supply requests and
// firmware upload markers. Assumes the bench calls its tasks in order.
`timescale 1ns/1ps
module bfcc_host (
   input wire logic clk,
   output logic cfg_packet,
   output logic pkt_bias_on,
   output logic pkt_cooler_on,
   output logic supply_on_cmd,
   output logic upload_start,
   output logic upload_done
);
   // ==========================================================
   // Idle levels
   // ==========================================================
   // Everything is quiet at power-up so nothing is mistaken for a packet.
   initial begin
      cfg_packet = 1'b0;
      pkt_bias_on = 1'b0;
      pkt_cooler_on = 1'b0;
      supply_on_cmd = 1'b0;
      upload_start = 1'b0;
      upload_done = 1'b0;
   end
   // One-cycle packet; supply wants are inverted after it so that a
   // design sampling them late sees the wrong value.
   task automatic send_cfg(input logic bias, input logic cool);
      @(posedge clk);
      cfg_packet <= 1'b1;
      pkt_bias_on <= bias;
      pkt_cooler_on <= cool;
      @(posedge clk);
      cfg_packet <= 1'b0;
      pkt_bias_on <= ~bias;
      pkt_cooler_on <= ~cool;
   endtask : send_cfg
   // Supply-board power request from the host.
   task automatic ask_supply;
      @(posedge clk);
      supply_on_cmd <= 1'b1;
      @(posedge clk);
      supply_on_cmd <= 1'b0;
   endtask : ask_supply
   // Start or end of a firmware upload; the host power-cycles afterwards.
   task automatic upload_mark(input logic fin);
      @(posedge clk);
      upload_start <= ~fin;
      upload_done <= fin;
      @(posedge clk);
      upload_start <= 1'b0;
      upload_done <= 1'b0;
   endtask : upload_mark
endmodule : bfcc_host

// ### sim/bfcc_top_bench.sv
// Self-checking bench for the boot-flag configuration block.
// Assumes bfcc_pkg, the design files and the host model compile first.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
   bad_count++; $display("mismatch %s expected %0h seen %0h", nm, ex, got); \
   end end
module bfcc_top_bench;
   import bfcc_pkg::*;
   localparam int W = 16;
   localparam int DLY = 20;
   int bad_count = 0;
   int tests_run = 0;
   logic clk = 1'b0, rst = 1'b1, flag_nv_boot = 1'b0, flag_baud_fast = 1'b1;
   logic flag_pol_pos = 1'b1, flag_adc_invert = 1'b0, flag_fast_slow4 = 1'b0;
   logic flag_use_offset = 1'b0, flag_write = 1'b0, strap_pol_pos = 1'b1;
   logic clk80_sel = 1'b0, legacy_emul = 1'b1, pkt_invert = 1'b0;
   logic nv_bias_on = 1'b0, nv_cooler_on = 1'b0, peak_minmax_cmd = 1'b0;
   logic peak_minmax_we = 1'b0, hist_fast_cmd = 1'b0, hist_fast_we = 1'b0;
   logic [W-1:0] flag_offset = '0, adc_in = '0, restored = '0;
   logic [W-1:0] shaped = '0, fast_in = '0, adc_out, hist_data;
   logic [10:0] peak_req = 11'h064, fast_peak_ns, peak_eff;
   logic cfg_packet, supply_on_cmd, pkt_bias_on, pkt_cooler_on;
   logic upload_start, upload_done, configured, supply_board_en;
   logic detector_bias_supply_en, thermoelectric_cooler_supply_en;
   logic pol_mismatch, hist_valid, upload_busy;
   logic [7:0] status_byte23;
   logic [15:0] baud_div;
   // ==========================================================
   // Clock, design and host
   // ==========================================================
   // A short supply delay keeps the power-up sequence quick in simulation.
   always #4 clk = ~clk;
   bfcc_top #(.W(W), .SUPPLY_DELAY(DLY)) i_dut (.clk(clk), .rst(rst),
      .flag_nv_boot(flag_nv_boot), .flag_baud_fast(flag_baud_fast),
      .flag_pol_pos(flag_pol_pos), .flag_adc_invert(flag_adc_invert),
      .flag_fast_slow4(flag_fast_slow4), .flag_use_offset(flag_use_offset),
      .flag_offset(flag_offset), .flag_write(flag_write),
      .strap_pol_pos(strap_pol_pos), .clk80_sel(clk80_sel),
      .legacy_emul(legacy_emul), .pkt_invert(pkt_invert),
      .cfg_packet(cfg_packet), .supply_on_cmd(supply_on_cmd),
      .nv_bias_on(nv_bias_on), .nv_cooler_on(nv_cooler_on),
      .pkt_bias_on(pkt_bias_on), .pkt_cooler_on(pkt_cooler_on),
      .peak_minmax_cmd(peak_minmax_cmd), .peak_minmax_we(peak_minmax_we),
      .hist_fast_cmd(hist_fast_cmd), .hist_fast_we(hist_fast_we),
      .upload_start(upload_start), .upload_done(upload_done),
      .peak_req(peak_req), .adc_in(adc_in), .restored(restored),
      .shaped(shaped), .fast_in(fast_in), .configured(configured),
      .status_byte23(status_byte23), .supply_board_en(supply_board_en),
      .detector_bias_supply_en(detector_bias_supply_en),
      .thermoelectric_cooler_supply_en(thermoelectric_cooler_supply_en),
      .pol_mismatch(pol_mismatch), .baud_div(baud_div),
      .fast_peak_ns(fast_peak_ns), .peak_eff(peak_eff), .adc_out(adc_out),
      .hist_data(hist_data), .hist_valid(hist_valid),
      .upload_busy(upload_busy));
   bfcc_host i_host (.clk(clk), .cfg_packet(cfg_packet),
      .pkt_bias_on(pkt_bias_on), .pkt_cooler_on(pkt_cooler_on),
      .supply_on_cmd(supply_on_cmd), .upload_start(upload_start),
      .upload_done(upload_done));
   // ==========================================================
   // Helpers
   // ==========================================================
   // Waits edges, then a little more so registered outputs have settled.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // Stores a new flag set; only the offset enable and offset value show before the next power-up.
   task automatic store(input logic nv, fast, s4, inv, uo);
      @(posedge clk);
      flag_nv_boot <= nv;
      flag_baud_fast <= fast;
      flag_fast_slow4 <= s4;
      flag_adc_invert <= inv;
      flag_use_offset <= uo;
      flag_write <= 1'b1;
      @(posedge clk);
      flag_write <= 1'b0;
      tick(1);
   endtask : store
   task automatic power_cycle;
      @(posedge clk);
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      tick(3);
   endtask : power_cycle
   // Bounded wait for the supply board; running out ends the run.
   task automatic wait_sup(output int n);
      n = 0;
      while (supply_board_en !== 1'b1) begin
         if (n == 100) begin
            bad_count++;
            test_done;
         end
         tick(1);
         n++;
      end
   endtask : wait_sup
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done
   // ==========================================================
   // Scenarios
   // ==========================================================
   // Unconfigured boot: an early supply request must be refused.
   task automatic t_unconfigured;
      store(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      power_cycle;
      `CHK("configured", 1'b0, configured)
      `CHK("status cfg", 1'b0, status_byte23[STATUS_CFG_BIT])
      `CHK("baud", BAUD_DIV_FAST, baud_div)
      i_host.ask_supply;
      tick(3);
      `CHK("early supply", 1'b0, supply_board_en)
      i_host.send_cfg(1'b1, 1'b1);
      tick(2);
      `CHK("status cfg", 1'b1, status_byte23[STATUS_CFG_BIT])
      `CHK("supply wait", 1'b0, supply_board_en)
      i_host.ask_supply;
      tick(3);
      `CHK("supply", 1'b1, supply_board_en)
      `CHK("bias", 1'b1, detector_bias_supply_en)
      `CHK("cooler", 1'b1, thermoelectric_cooler_supply_en)
      $display("done unconfigured");
   endtask : t_unconfigured
   // Nonvolatile boot; with strap low the cooler is stored off and polarity clashes.
   task automatic t_nv_boot(input logic strap);
      int n;
      @(posedge clk);
      nv_bias_on <= 1'b1;
      nv_cooler_on <= strap;
      strap_pol_pos <= strap;
      store(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      power_cycle;
      `CHK("supply early", 1'b0, supply_board_en)
      wait_sup(n);
      `CHK("delay", 1'b1, (n + 3 >= DLY) && (n + 3 <= DLY + 5))
      `CHK("configured", 1'b1, configured)
      `CHK("cooler", strap, thermoelectric_cooler_supply_en)
      `CHK("bias", strap, detector_bias_supply_en)
      `CHK("mismatch", ~strap, pol_mismatch)
      $display("done nv boot");
   endtask : t_nv_boot
   // Power-cycle flags hold their latched value; clock choice is live.
   task automatic t_latched;
      store(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      `CHK("baud held", BAUD_DIV_FAST, baud_div)
      `CHK("shaping held", FAST_NS_20, fast_peak_ns)
      power_cycle;
      `CHK("baud slow", BAUD_DIV_SLOW, baud_div)
      `CHK("fast 20 x4", FAST_NS_20_SLOW, fast_peak_ns)
      @(posedge clk);
      clk80_sel <= 1'b1;
      tick(2);
      `CHK("fast 80 x4", FAST_NS_80_SLOW, fast_peak_ns)
      store(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      power_cycle;
      `CHK("fast 80", FAST_NS_80, fast_peak_ns)
      $display("done latched");
   endtask : t_latched
   // Peaking limits: floor clamp at both clock rates, ceiling clamp with clk80_sel low, one value in range.
   task automatic t_peak;
      logic [10:0] rq [4] = '{11'h005, 11'h7D0, 11'h064, 11'h001};
      logic [10:0] ex [4] = '{PEAK_MIN_20, PEAK_MAX_20, 11'h064, PEAK_MIN_80};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         clk80_sel <= (i == 3);
         peak_req <= rq[i];
         tick(3);
         `CHK("peak", ex[i], peak_eff)
      end
      $display("done peak");
   endtask : t_peak
   // Inversion source, histogram source and spectrum offset.
   task automatic t_samples;
      @(posedge clk);
      flag_offset <= 16'h0010;
      adc_in <= 16'h1234;
      restored <= 16'h0100;
      shaped <= 16'h0100;
      fast_in <= 16'h0A0A;
      hist_fast_cmd <= 1'b1;
      hist_fast_we <= 1'b1;
      @(posedge clk);
      hist_fast_we <= 1'b0;
      tick(3);
      `CHK("hist fast", 16'h0A0A, hist_data)
      store(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
      power_cycle;
      `CHK("adc inv", 16'hEDCB, adc_out)
      `CHK("hist slow", 16'h0110, hist_data)
      store(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
      tick(2);
      `CHK("no offset", 16'h0100, hist_data)
      @(posedge clk);
      legacy_emul <= 1'b0;
      tick(2);
      `CHK("adc pkt", 16'h1234, adc_out)
      $display("done samples");
   endtask : t_samples
   task automatic t_upload;
      i_host.upload_mark(1'b0);
      tick(1);
      `CHK("busy", 1'b1, upload_busy)
      i_host.upload_mark(1'b1);
      tick(1);
      `CHK("idle", 1'b0, upload_busy)
      power_cycle;
      $display("done upload");
   endtask : t_upload
   // One-sample excursion of the shaped stream from its 16'h0100 rest level.
   // Returns the histogram strobe one edge after the extremum is visible.
   task automatic blip(input logic [W-1:0] v, output logic seen);
      @(posedge clk);
      shaped <= v;
      @(posedge clk);
      shaped <= 16'h0100;
      tick(1);
      seen = hist_valid;
   endtask : blip
   // Peak detect mode: minima pass only when selected, and not after power-up.
   task automatic t_peakdet;
      logic s;
      i_host.send_cfg(1'b0, 1'b0);
      tick(2);
      blip(16'h0200, s);
      `CHK("max", 1'b1, s)
      blip(16'h0080, s);
      `CHK("min off", 1'b0, s)
      @(posedge clk);
      peak_minmax_cmd <= 1'b1;
      peak_minmax_we <= 1'b1;
      @(posedge clk);
      peak_minmax_we <= 1'b0;
      blip(16'h0080, s);
      `CHK("min on", 1'b1, s)
      power_cycle;
      i_host.send_cfg(1'b0, 1'b0);
      tick(2);
      blip(16'h0080, s);
      `CHK("min reset", 1'b0, s)
      $display("done peak detect");
   endtask : t_peakdet
   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      // The flag store has no reset, so give it contents before power-up.
      store(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      tick(3);
      t_unconfigured;
      t_nv_boot(1'b1);
      t_nv_boot(1'b0);
      t_latched;
      t_peak;
      t_samples;
      t_upload;
      t_peakdet;
      test_done;
   end
endmodule : bfcc_top_bench
